// ---- hw/optical_module_control_status.sv ----
/*
  Control and status logic of an optical transceiver module: laser enable
  sequencing, fault and light-missing flags, rate selects, and the
  management register file reached over AHB-Lite.
  Assumes a single 25 MHz hclk, inputs synchronous to it, and an AHB-Lite
  master doing single word transfers. The laser-off pin is pulled up
  outside, so an open pin arrives here as 1.
*/
//
// Function
// - the laser is kept off whenever the laser-off request reads 1 or is left open.
// - with the laser-off request at 0 the laser transmits normally.
// - the laser-fault output is high on a detected laser or safety fault, low otherwise; here it stays latched until a fault clear or a laser-off request.
// - the light-missing output is high whenever received light is below the standard level.
// - a management port gives identity, diagnostics and control to the host.
// - the management port gives live received power, bias current and output power.
// - the module-absent line is tied to module ground so a present module reads low.
// - the receive rate select chooses above 4.25 GBd when high, at or below when low.
// - the transmit rate select chooses above 4.25 GBd when high, at or below when low.
// - after the laser-off request rises, the laser is off within 100 us.
// - after the laser-off request falls in normal operation, the laser is on within 2 ms.
// - the management port is ready within 300 ms of power-on or insertion.
// - the module is fully operational within 300 ms of power-up, release or fault recovery; here power-up and fault recovery take 300 ms plus 1 ms.
`timescale 1ns/1ps
`include "optical_ctl_defs.svh"

module optical_module_control_status #(
  parameter int unsigned START_CYCLES = `START_CYCLES,
  parameter int unsigned ON_CYCLES    = `ON_CYCLES
) (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic                         hready,
  input  wire logic [31:0]                  hwdata,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire optical_ctl_pkg::pins_in_t    pins,
  input  wire optical_ctl_pkg::monitor_t    monitor,
  output logic                              laser_enable,
  output logic                              laser_fault_flag_alt,
  output logic                              light_missing_flag,
  output logic                              module_absent_line,
  output logic                              rx_rate_high,
  output logic                              tx_rate_high,
  output logic                              irq
);

  localparam int unsigned OFF_CYCLES = `OFF_CYCLES;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [11:0] word_index(input logic [31:0] a);
    word_index = a[13:2];
  endfunction

  function automatic logic addr_is(input logic [31:0] a, input logic [7:0] off);
    addr_is = (a[31:8] == 24'h0) && (a[7:0] == off);
  endfunction

  // ****************************************************************
  // bus address phase capture
  // ****************************************************************
  logic        dp_valid;
  logic        dp_write;
  logic [31:0] dp_addr;
  logic [1:0]  ctrl;
  logic [3:0]  irq_status;
  logic [3:0]  irq_mask;
  logic [22:0] timer;
  logic        ready;
  logic        mgmt_ready;
  logic        fault_latched;
  logic        light_prev;
  optical_ctl_pkg::laser_state_t state;
  optical_ctl_pkg::monitor_t     mon_q;

  wire logic addr_phase = hsel && htrans[1] && hready;
  wire logic wr_ctrl    = dp_valid && dp_write && addr_is(dp_addr, `OFF_CTRL);
  wire logic wr_mask    = dp_valid && dp_write && addr_is(dp_addr, `OFF_IRQ_MASK);
  wire logic rd_irq     = addr_phase && !hwrite && addr_is(haddr, `OFF_IRQ_STATUS);
  // laser off when pin high, software forces off, or fault latched
  wire logic want_off   = pins.laser_off_req || ctrl[`CTRL_SW_OFF] || fault_latched;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
    end else begin
      dp_valid <= addr_phase;
    end
  end

  // address and direction only matter while dp_valid is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= 32'h0;
    end else begin
      dp_write <= hwrite;
      dp_addr  <= haddr;
    end
  end

  // ****************************************************************
  // control and mask registers
  // ****************************************************************
  // the fault clear bit is a one-cycle pulse; the laser-off bit holds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_ctrl && mgmt_ready) begin
      ctrl <= hwdata[1:0];
    end else begin
      ctrl[`CTRL_FAULT_CLR] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= `MASK_RESET;
    end else if (wr_mask) begin
      irq_mask <= hwdata[3:0];
    end
  end

  // ****************************************************************
  // laser sequencing
  // ****************************************************************
  // a new fault wins over a clear arriving in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_latched <= 1'b0;
    end else if (pins.laser_fault_det) begin
      fault_latched <= 1'b1;
    end else if (ctrl[`CTRL_FAULT_CLR] || pins.laser_off_req) begin
      fault_latched <= 1'b0;
    end
  end

  // one counter serves start-up and turn-on; only one runs at a time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state         <= optical_ctl_pkg::st_init;
      timer         <= 23'h0;
      ready         <= 1'b0;
      laser_enable  <= 1'b0;
    end else begin
      case (state)
        optical_ctl_pkg::st_init: begin
          laser_enable <= 1'b0;
          if (timer >= 23'(START_CYCLES - 1)) begin
            ready <= 1'b1;
            timer <= 23'h0;
            state <= want_off ? optical_ctl_pkg::st_off : optical_ctl_pkg::st_on;
          end else begin
            timer <= timer + 23'h1;
          end
        end
        optical_ctl_pkg::st_on: begin
          // enable rises once the turn-on delay is spent, well inside 2 ms
          if (want_off) begin
            laser_enable <= 1'b0;
            timer        <= 23'h0;
            state        <= fault_latched ? optical_ctl_pkg::st_fault : optical_ctl_pkg::st_off;
          end else if (timer >= 23'(ON_CYCLES / 2)) begin
            laser_enable <= 1'b1;
          end else begin
            timer <= timer + 23'h1;
          end
        end
        optical_ctl_pkg::st_off: begin
          laser_enable <= 1'b0;
          // a fault raised while dark still costs a full start-up once cleared
          if (fault_latched) begin
            state <= optical_ctl_pkg::st_fault;
          end else if (!want_off) begin
            timer <= 23'h0;
            state <= optical_ctl_pkg::st_on;
          end
        end
        optical_ctl_pkg::st_fault: begin
          laser_enable <= 1'b0;
          // recovery restarts the full start-up time
          if (!fault_latched) begin
            timer <= 23'h0;
            ready <= 1'b0;
            state <= optical_ctl_pkg::st_init;
          end
        end
        default: begin
          state <= optical_ctl_pkg::st_init;
        end
      endcase
    end
  end

  // ****************************************************************
  // status pins and monitors
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      laser_fault_flag_alt <= 1'b0;
      light_missing_flag   <= 1'b0;
      light_prev           <= 1'b0;
    end else begin
      laser_fault_flag_alt <= fault_latched;
      light_missing_flag   <= pins.light_low;
      light_prev           <= pins.light_low;
    end
  end

  // tied to module ground: a fitted module always reads as present
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_absent_line <= 1'b0;
    end else begin
      module_absent_line <= 1'b0;
    end
  end

  // rate selects are only reported; nothing here changes speed with them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_rate_high <= 1'b0;
      tx_rate_high <= 1'b0;
    end else begin
      rx_rate_high <= pins.rx_rate_select;
      tx_rate_high <= pins.tx_rate_select;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mon_q <= '0;
    end else begin
      mon_q <= monitor;
    end
  end

  // ****************************************************************
  // management port readiness
  // ****************************************************************
  // stays up through a fault restart; only a reset drops it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mgmt_ready <= 1'b0;
    end else if (ready) begin
      mgmt_ready <= 1'b1;
    end
  end

  // ****************************************************************
  // interrupt status, set wins over read clear
  // ****************************************************************
  logic [3:0] events;
  always_comb begin
    events = 4'h0;
    events[`EV_FAULT]      = pins.laser_fault_det && !fault_latched;
    events[`EV_LIGHT_MISS] = pins.light_low && !light_prev;
    events[`EV_READY]      = ready && !mgmt_ready;
    events[`EV_LIGHT_BACK] = !pins.light_low && light_prev;
  end

  // an event in the reading cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 4'h0;
    end else begin
      irq_status <= (rd_irq ? 4'h0 : irq_status) | events;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ****************************************************************
  // read data, zero wait states
  // ****************************************************************
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0;
    if (haddr[31:8] == 24'h0) begin
      case (haddr[7:0])
        `OFF_CTRL:       next_rdata = {30'h0, ctrl};
        `OFF_STATUS: begin
          next_rdata[`ST_LASER_ON]     = laser_enable;
          next_rdata[`ST_FAULT]        = fault_latched;
          next_rdata[`ST_LIGHT_MISS]   = light_missing_flag;
          next_rdata[`ST_READY]        = ready;
          next_rdata[`ST_MGMT_READY]   = mgmt_ready;
          next_rdata[`ST_RX_RATE]      = rx_rate_high;
          next_rdata[`ST_TX_RATE]      = tx_rate_high;
          next_rdata[`ST_LASER_OFF_IN] = pins.laser_off_req;
        end
        `OFF_IRQ_STATUS: next_rdata = {28'h0, irq_status};
        `OFF_IRQ_MASK:   next_rdata = {28'h0, irq_mask};
        `OFF_RX_POWER:   next_rdata = {20'h0, mon_q.rx_power};
        `OFF_BIAS:       next_rdata = {20'h0, mon_q.bias};
        `OFF_TX_POWER:   next_rdata = {20'h0, mon_q.tx_power};
        `OFF_MGMT:       next_rdata = {31'h0, mgmt_ready};
        `OFF_ID:         next_rdata = `ID_VALUE; // arbitrary identity value
        default:         next_rdata = 32'h0;
      endcase
    end
  end

  // no wait states and no errors: every access ends in one data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (addr_phase && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  logic [11:0] unused_idx;
  assign unused_idx = word_index(haddr) ^ {9'h0, hsize};

endmodule

// ---- hw/optical_ctl_defs.svh ----
/*
  Register offsets, field positions, reset values and timing counts for the
  optical module control and status block.
  Assumes a 25 MHz hclk; included by the hw module and by the bench.
*/
`ifndef OPTICAL_CTL_DEFS_SVH
`define OPTICAL_CTL_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_IRQ_STATUS  8'h08
`define OFF_IRQ_MASK    8'h0c
`define OFF_RX_POWER    8'h10
`define OFF_BIAS        8'h14
`define OFF_TX_POWER    8'h18
`define OFF_MGMT        8'h1c
`define OFF_ID          8'h20

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_SW_OFF     0
`define CTRL_FAULT_CLR  1
`define ST_LASER_ON     0
`define ST_FAULT        1
`define ST_LIGHT_MISS   2
`define ST_READY        3
`define ST_MGMT_READY   4
`define ST_RX_RATE      5
`define ST_TX_RATE      6
`define ST_LASER_OFF_IN 7
`define EV_FAULT        0
`define EV_LIGHT_MISS   1
`define EV_READY        2
`define EV_LIGHT_BACK   3
`define EV_W            4

// ****************************************************************
// reset values and timing
// ****************************************************************
`define CTRL_RESET      2'h0
`define MASK_RESET      4'h0
`define ID_VALUE        32'h0000_5a01
`define CLK_MHZ         25
`define T_OFF_US        100
`define T_ON_MS         2
`define T_START_MS      300
`define OFF_CYCLES      (`T_OFF_US * `CLK_MHZ)
`define ON_CYCLES       (`T_ON_MS * 1000 * `CLK_MHZ)
`define START_CYCLES    (`T_START_MS * 1000 * `CLK_MHZ)

`endif

// ---- hw/optical_ctl_pkg.sv ----
/*
  Types for the optical module control and status block.
  Takes no values from optical_ctl_defs.svh; state codes and field widths are set here.
*/
package optical_ctl_pkg;

  // ****************************************************************
  // laser sequencing states, gray along power-up path
  // ****************************************************************
  typedef enum logic [1:0] {
    st_init    = 2'b00,
    st_on      = 2'b01,
    st_off     = 2'b11,
    st_fault   = 2'b10
  } laser_state_t;

  typedef struct packed {
    logic [11:0] rx_power;
    logic [11:0] bias;
    logic [11:0] tx_power;
  } monitor_t;

  typedef struct packed {
    logic laser_off_req;
    logic laser_fault_det;
    logic light_low;
    logic rx_rate_select;
    logic tx_rate_select;
  } pins_in_t;

endpackage

// ---- verif/optical_ctl_monitor.sv ----
/* checker for the optical module control block, bound to its top module.
   assumes one hclk and an asynchronous active-low hresetn. */
`timescale 1ns/1ps
module optical_ctl_monitor #(
  parameter int unsigned START_CYCLES = 50,
  parameter int unsigned ON_CYCLES    = 20
) (
  input wire logic                      hclk,
  input wire logic                      hresetn,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  input wire optical_ctl_pkg::pins_in_t pins,
  input wire logic                      laser_enable,
  input wire logic                      laser_fault_flag_alt,
  input wire logic                      light_missing_flag,
  input wire logic                      module_absent_line,
  input wire logic                      rx_rate_high,
  input wire logic                      tx_rate_high
);
  int unsigned up;
  int unsigned low;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************
  // counters: since reset, and since the laser was last free to start
  // ****************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up <= 0;
    end else if (up < START_CYCLES) begin
      up <= up + 1;
    end
  end
  // restart after fault clear costs a full start-up, hence the wide margin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low <= 0;
    end else if (pins.laser_off_req || pins.laser_fault_det || laser_fault_flag_alt) begin
      low <= 0;
    end else if (low < START_CYCLES + ON_CYCLES + 8) begin
      low <= low + 1;
    end
  end
  a_pin_off_dark:
    assert property (pins.laser_off_req ##1 pins.laser_off_req |-> !laser_enable)
    else $error("laser on while off request held");
  a_fault_dark:
    assert property (laser_fault_flag_alt [*2] |-> !laser_enable)
    else $error("laser on while fault latched");
  a_early_dark:
    assert property (up < START_CYCLES |-> !laser_enable) else $error("laser on during start-up");
  a_release_lights:
    assert property (low == START_CYCLES + ON_CYCLES + 8 |-> laser_enable)
    else $error("laser still off after release");
  a_light_follows:
    assert property (1'b1 |=> light_missing_flag == $past(pins.light_low))
    else $error("light flag does not follow input");
  a_rx_rate:
    assert property (1'b1 |=> rx_rate_high == $past(pins.rx_rate_select))
    else $error("rx rate does not follow input");
  a_tx_rate:
    assert property (1'b1 |=> tx_rate_high == $past(pins.tx_rate_select))
    else $error("tx rate does not follow input");
  a_absent_low:
    assert property (module_absent_line == 1'b0) else $error("absent line not low");
  a_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus not ready or error");
  c_laser_on: cover property ($rose(laser_enable));
  c_fault: cover property ($rose(laser_fault_flag_alt));
  c_pin_off: cover property ($fell(laser_enable) && pins.laser_off_req);
endmodule

bind optical_module_control_status optical_ctl_monitor #(
  .START_CYCLES(START_CYCLES),
  .ON_CYCLES(ON_CYCLES)
) mon (
  .hclk(hclk),
  .hresetn(hresetn),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .pins(pins),
  .laser_enable(laser_enable),
  .laser_fault_flag_alt(laser_fault_flag_alt),
  .light_missing_flag(light_missing_flag),
  .module_absent_line(module_absent_line),
  .rx_rate_high(rx_rate_high),
  .tx_rate_high(tx_rate_high)
);

// ---- verif/host_pins_model.sv ----
/* host board model: drives the module input pins, syncs its status lines.
   assumes bench commands change just after hclk rises. */
`timescale 1ns/1ps
module host_pins_model #(
  parameter int unsigned INIT = 60
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 tx_wanted,
  input  wire logic                 fault_inject,
  input  wire logic                 light_low,
  input  wire logic [1:0]           rates,
  input  wire logic                 absent,
  input  wire logic                 fault_flag,
  output optical_ctl_pkg::pins_in_t pins,
  output logic                      fault_seen
);
  logic [1:0]  abs_s;
  logic [1:0]  flt_s;
  int unsigned settle;
  // ****************
  // status levels are asynchronous to the host
  // ****************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abs_s <= 2'h3;
      flt_s <= 2'h0;
    end else begin
      abs_s <= {abs_s[0], absent};
      flt_s <= {flt_s[0], fault_flag};
    end
  end
  assign fault_seen = flt_s[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle <= 0;
    end else if (abs_s[1]) begin
      settle <= 0;
    end else if (settle < INIT) begin
      settle <= settle + 1;
    end
  end
  // ****************
  // pin drive; an undriven off request reads as 1
  // ****************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins <= 5'h10; // off request high, all else low
    end else begin
      pins.laser_off_req <= !(tx_wanted && settle == INIT);
      pins.laser_fault_det <= fault_inject;
      pins.light_low <= light_low;
      pins.rx_rate_select <= rates[1];
      pins.tx_rate_select <= rates[0];
    end
  end
endmodule

// ---- verif/optical_module_control_status_bench.sv ----
/* self-checking bench for the optical module control block.
   assumes the host model and checker files are compiled first. */
`timescale 1ns/1ps
`include "optical_ctl_defs.svh"
module optical_module_control_status_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, rates;
  logic [2:0] hsize;
  optical_ctl_pkg::pins_in_t pins;
  optical_ctl_pkg::monitor_t monitor;
  logic laser_enable, fault_flag, light_flag, absent, rx_hi, tx_hi, irq;
  logic tx_wanted, fault_inject, light_low, fault_seen;
  int bad_count, checks, ev;
  optical_module_control_status #(.START_CYCLES(50), .ON_CYCLES(20)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .monitor(monitor),
    .laser_enable(laser_enable), .laser_fault_flag_alt(fault_flag),
    .light_missing_flag(light_flag), .module_absent_line(absent),
    .rx_rate_high(rx_hi), .tx_rate_high(tx_hi), .irq(irq));
  host_pins_model #(.INIT(60)) host (
    .hclk(hclk), .hresetn(hresetn), .tx_wanted(tx_wanted), .fault_inject(fault_inject),
    .light_low(light_low), .rates(rates), .absent(absent), .fault_flag(fault_flag),
    .pins(pins), .fault_seen(fault_seen));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************
  // single word transfer, result left in r
  // ****************
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task wait_laser(input logic want);
    int n;
    n = 0;
    while (laser_enable !== want && n < 400) begin
      @(posedge hclk);
      n++;
    end
    check("laser_enable", laser_enable, want);
  endtask
  initial begin
    #(40 * 20000);
    bad_count++;
    stop_test;
  end
  initial begin
    void'($urandom(56694));
    {hresetn, hsel, hwrite, tx_wanted, fault_inject, light_low} = '0;
    {haddr, hwdata, htrans, rates, monitor} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    tx_wanted <= 1'b1;
    repeat (40) @(posedge hclk);
    check("absent", absent, 0);
    check("early laser", laser_enable, 0);
    wait_laser(1);
    xfer(0, `OFF_ID, 0);
    check("id", r, `ID_VALUE);
    xfer(0, 32'h40, 0);
    check("unmapped", r, 0);
    xfer(0, `OFF_IRQ_MASK, 0);
    check("mask reset", r, `MASK_RESET);
    for (int i = 0; i < 4; i++) begin
      monitor <= {4'($urandom()), $urandom()};
      rates <= 2'(i);
      light_low <= 1'($urandom());
      repeat (3) @(posedge hclk);
      check("light", light_flag, light_low);
      check("rx rate", rx_hi, rates[1]);
      check("tx rate", tx_hi, rates[0]);
      xfer(0, `OFF_RX_POWER, 0);
      check("rx power", r, {20'h0, monitor.rx_power});
      xfer(0, `OFF_BIAS, 0);
      check("bias", r, {20'h0, monitor.bias});
      xfer(0, `OFF_TX_POWER, 0);
      check("tx power", r, {20'h0, monitor.tx_power});
    end
    light_low <= 1'b0;
    repeat (3) @(posedge hclk);
    xfer(0, `OFF_IRQ_STATUS, 0);
    xfer(0, `OFF_IRQ_STATUS, 0);
    check("status cleared", r, 0);
    light_low <= 1'b1;
    repeat (3) @(posedge hclk);
    check("masked irq", irq, 0);
    xfer(1, `OFF_IRQ_MASK, 32'hf);
    repeat (2) @(posedge hclk);
    check("irq", irq, 1);
    light_low <= 1'b0;
    ev = (1 << `EV_LIGHT_MISS) | (1 << `EV_LIGHT_BACK);
    repeat (3) @(posedge hclk);
    xfer(0, `OFF_IRQ_STATUS, 0);
    check("light events", r, ev);
    repeat (2) @(posedge hclk);
    check("irq clear", irq, 0);
    fault_inject <= 1'b1;
    @(posedge hclk);
    fault_inject <= 1'b0;
    repeat (3) @(posedge hclk);
    check("fault", fault_flag, 1);
    check("fault laser", laser_enable, 0);
    repeat (2) @(posedge hclk);
    check("fault seen", fault_seen, 1);
    xfer(0, `OFF_IRQ_STATUS, 0);
    check("fault event", r, 1 << `EV_FAULT);
    xfer(1, `OFF_CTRL, 32'h2);
    repeat (3) @(posedge hclk);
    check("fault clear", fault_flag, 0);
    wait_laser(1);
    tx_wanted <= 1'b0;
    repeat (4) @(posedge hclk);
    check("pin off", laser_enable, 0);
    xfer(1, `OFF_CTRL, 32'h1);
    tx_wanted <= 1'b1;
    repeat (30) @(posedge hclk);
    check("software off", laser_enable, 0);
    ev = (1 << `ST_READY) | (1 << `ST_MGMT_READY);
    ev = ev | (int'(rates[1]) << `ST_RX_RATE) | (int'(rates[0]) << `ST_TX_RATE);
    xfer(0, `OFF_STATUS, 0);
    check("status dark", r, ev);
    xfer(1, `OFF_CTRL, 32'h0);
    wait_laser(1);
    xfer(0, `OFF_STATUS, 0);
    check("status lit", r, ev | (1 << `ST_LASER_ON));
    xfer(0, `OFF_MGMT, 0);
    check("mgmt ready", r, 1);
    stop_test;
  end
endmodule
